// [verilog/dmpd_top.sv]
// dual-modulus feedback divider with phase-frequency detector
// How it works
// - divisor ratio comes from a serially loaded command word
// - each division cycle with a nonzero swallow digit starts with the prescaler dividing by eleven
// - swallow counter allows its count of eleven periods, then selects ten
// - each prescaler pulse in large phase decrements both counters by one
// - with swallow at zero, divide by ten until main reaches zero
// - main at zero emits one pulse, reloads both, returns to eleven unless swallow reloads zero
// - moduli are ten and eleven, swallow counter lives inside this divider
// - upper digits load main, lowest digit loads swallow; ratio ten main plus swallow
// - detector pulses one output while divided and reference differ
// - feedback fast or leading pulses pump down low, pump up stays high
// - feedback slow or lagging pulses pump up low, pump down stays high
// - matched inputs give only a brief simultaneous low on both
// - slow feedback steers oscillator up, fast feedback steers it down
module dmpd_top (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic osc_in,
  input  wire logic ref_in,
  input  wire logic cmd_clk_in,
  input  wire logic cmd_data_in,
  input  wire logic cmd_load_in,
  output logic      divided_out,
  output logic      pump_up_n_out,
  output logic      pump_down_n_out
);
  localparam int MW = dmpd_pkg::MAIN_W;
  localparam int DW = dmpd_pkg::DIGIT_W;

  dmpd_cmd_if cmd ();

  logic [1:0]          sync1;
  logic [1:0]          sync2;
  logic [1:0]          prev;
  logic [DW-1:0]       pre_cnt;
  logic [MW-1:0]       main_cnt;
  logic [DW-1:0]       swallow_cnt;
  logic [MW-1:0]       pend_main;
  logic [DW-1:0]       pend_swallow;
  logic                fb_pulse;
  dmpd_pkg::dmpd_pfd_e state;
  dmpd_pkg::dmpd_pfd_e next_state;
  logic                up_hold;
  logic                down_hold;

  // decimal digits to binary count
  function automatic logic [MW-1:0] bcd3_to_bin(input logic [dmpd_pkg::MAIN_BCD_W-1:0] bcd);
    bcd3_to_bin = MW'(bcd[11:8]) * dmpd_pkg::WEIGHT_HUNDRED
                + MW'(bcd[7:4]) * dmpd_pkg::WEIGHT_TEN
                + MW'(bcd[3:0]);
  endfunction

  // serial command receiver
  dmpd_serial_rx u_dmpd_serial_rx (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .cmd_clk_in  (cmd_clk_in),
    .cmd_data_in (cmd_data_in),
    .cmd_load_in (cmd_load_in),
    .cmd         (cmd.rx)
  );

  // oscillator and reference pins pass two flops, then edge history
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev  <= 2'h0;
    end else begin
      sync1 <= {ref_in, osc_in};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // edge and divider decode
  wire logic          osc_edge  = sync2[0] & ~prev[0];
  wire logic          ref_edge  = sync2[1] & ~prev[1];
  wire logic          large_mod = swallow_cnt != dmpd_pkg::SW_ZERO;
  wire logic [DW-1:0] modulus   = large_mod ? dmpd_pkg::MOD_LARGE
                                            : dmpd_pkg::MOD_SMALL;
  wire logic          pre_term  = osc_edge && (pre_cnt == modulus - dmpd_pkg::PRE_ONE);
  wire logic          reload    = pre_term && (main_cnt <= dmpd_pkg::MAIN_ONE);

  // pending ratio, applied only at reload
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pend_main    <= dmpd_pkg::DEF_MAIN;
      pend_swallow <= dmpd_pkg::DEF_SWALLOW;
    end else if (cmd.word_valid) begin
      pend_main    <= bcd3_to_bin(cmd.main_bcd);
      pend_swallow <= cmd.swallow_bcd;
    end
  end

  // prescaler count of oscillator edges
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pre_cnt <= '0;
    end else if (osc_edge) begin
      pre_cnt <= pre_term ? '0 : pre_cnt + dmpd_pkg::PRE_ONE;
    end
  end

  // main and swallow counters
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      main_cnt    <= dmpd_pkg::DEF_MAIN;
      swallow_cnt <= dmpd_pkg::DEF_SWALLOW;
    end else if (reload) begin
      main_cnt    <= pend_main;
      swallow_cnt <= pend_swallow;
    end else if (pre_term) begin
      main_cnt <= main_cnt - dmpd_pkg::MAIN_ONE;
      if (large_mod) begin
        swallow_cnt <= swallow_cnt - dmpd_pkg::SW_ONE;
      end
    end
  end

  // one divided pulse per reload
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      fb_pulse <= 1'b0;
    end else begin
      fb_pulse <= reload;
    end
  end

  // detector flags still held in the current state
  always_comb begin
    case (state)
      dmpd_pkg::PFD_UP: begin
        up_hold   = 1'b1;
        down_hold = 1'b0;
      end
      dmpd_pkg::PFD_DOWN: begin
        up_hold   = 1'b0;
        down_hold = 1'b1;
      end
      default: begin
        up_hold   = 1'b0;
        down_hold = 1'b0;
      end
    endcase
  end

  // reference edge arms up, feedback edge arms down, both together clear
  always_comb begin
    case ({up_hold | ref_edge, down_hold | fb_pulse})
      2'b10:   next_state = dmpd_pkg::PFD_UP;
      2'b01:   next_state = dmpd_pkg::PFD_DOWN;
      2'b11:   next_state = dmpd_pkg::PFD_BOTH;
      default: next_state = dmpd_pkg::PFD_IDLE;
    endcase
  end

  // detector state and registered pump outputs
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state           <= dmpd_pkg::PFD_IDLE;
      pump_up_n_out   <= 1'b1;
      pump_down_n_out <= 1'b1;
      divided_out     <= 1'b0;
    end else begin
      state           <= next_state;
      pump_up_n_out   <= ~next_state[0];
      pump_down_n_out <= ~next_state[1];
      divided_out     <= fb_pulse;
    end
  end

  // divider and detector checks
  a_first_phase_large: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reload && pend_swallow != dmpd_pkg::SW_ZERO |=> modulus == dmpd_pkg::MOD_LARGE)
    else $error("cycle did not start with the large modulus");
  a_small_after_swallow: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    swallow_cnt == dmpd_pkg::SW_ZERO |-> modulus == dmpd_pkg::MOD_SMALL)
    else $error("large modulus used after swallow count ran out");
  a_main_decrements: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    pre_term && !reload |=> main_cnt == $past(main_cnt) - dmpd_pkg::MAIN_ONE)
    else $error("main counter not decremented on prescaler pulse");
  a_swallow_decrements: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    pre_term && !reload && large_mod |=> swallow_cnt == $past(swallow_cnt) - dmpd_pkg::SW_ONE)
    else $error("swallow counter not decremented on prescaler pulse");
  a_reload_pulse_out: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reload |=> fb_pulse ##1 divided_out && !fb_pulse)
    else $error("reload did not give exactly one divided pulse");
  a_word_at_reload: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !reload |=> main_cnt == $past(main_cnt) || main_cnt == $past(main_cnt) - dmpd_pkg::MAIN_ONE)
    else $error("main counter changed outside reload");
  a_reload_loads_pend: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    reload |=> main_cnt == $past(pend_main) && swallow_cnt == $past(pend_swallow))
    else $error("counters did not reload from the pending ratio");
  a_ref_raises_up: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ref_edge && !fb_pulse && !down_hold |=> state == dmpd_pkg::PFD_UP ##1 !pump_up_n_out)
    else $error("reference edge did not pulse pump up");
  a_fb_raises_down: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    fb_pulse && !ref_edge && !up_hold |=> state == dmpd_pkg::PFD_DOWN ##1 !pump_down_n_out)
    else $error("feedback edge did not pulse pump down");
  a_both_clear_fast: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == dmpd_pkg::PFD_BOTH && !ref_edge && !fb_pulse |=> state == dmpd_pkg::PFD_IDLE)
    else $error("simultaneous low lasted more than one cycle");
  a_one_side_holds: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == dmpd_pkg::PFD_DOWN && !ref_edge |=> state == dmpd_pkg::PFD_DOWN)
    else $error("pump down pulse ended before the reference edge");


  // main scenarios reached
  c_reload: cover property (@(posedge clock_in) disable iff (!rst_n_in) reload);
  c_word_taken: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    cmd.word_valid ##[1:1000] reload);
  c_both_low: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state == dmpd_pkg::PFD_BOTH);
  c_up_pulse: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state == dmpd_pkg::PFD_UP [*3]);
  c_down_pulse: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state == dmpd_pkg::PFD_DOWN [*3]);
endmodule

// [verilog/dmpd_pkg.sv]
// shared constants for the dual-modulus divider and phase detector
package dmpd_pkg;
  // decimal digit and command word layout
  localparam int DIGIT_W     = 4;
  localparam int MAIN_DIGITS = 3;
  localparam int MAIN_BCD_W  = DIGIT_W * MAIN_DIGITS;
  localparam int WORD_W      = MAIN_BCD_W + DIGIT_W;
  localparam int MAIN_W      = 10;
  localparam int SYNC_LEN    = 2;

  // prescaler moduli, large one first in every cycle with nonzero swallow
  localparam logic [DIGIT_W-1:0] MOD_LARGE = 4'hb;
  localparam logic [DIGIT_W-1:0] MOD_SMALL = 4'ha;
  localparam logic [DIGIT_W-1:0] PRE_ONE   = 4'h1;
  localparam logic [DIGIT_W-1:0] SW_ZERO   = 4'h0;
  localparam logic [DIGIT_W-1:0] SW_ONE    = 4'h1;

  // decimal weights for digit conversion
  localparam logic [MAIN_W-1:0] WEIGHT_HUNDRED = 10'h064;
  localparam logic [MAIN_W-1:0] WEIGHT_TEN     = 10'h00a;
  localparam logic [MAIN_W-1:0] MAIN_ONE       = 10'h001;

  // ratio used from reset until the first reload after a command word: 10*50+7
  localparam logic [MAIN_W-1:0]  DEF_MAIN    = 10'h032;
  localparam logic [DIGIT_W-1:0] DEF_SWALLOW = 4'h7;

  // phase detector states, gray along idle-up-both and idle-down-both
  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_UP   = 2'b01,
    PFD_BOTH = 2'b11,
    PFD_DOWN = 2'b10
  } dmpd_pfd_e;
endpackage

// [verilog/dmpd_cmd_if.sv]
// carrier for a decoded divisor command word between receiver and core
interface dmpd_cmd_if;
  logic                                 word_valid;
  logic [dmpd_pkg::MAIN_BCD_W-1:0]      main_bcd;
  logic [dmpd_pkg::DIGIT_W-1:0]         swallow_bcd;

  modport rx (output word_valid, output main_bcd, output swallow_bcd);
  modport core (input word_valid, input main_bcd, input swallow_bcd);
endinterface

// [verilog/dmpd_serial_rx.sv]
// serial command word receiver, sampled on the system clock
module dmpd_serial_rx (
  input  wire logic   clock_in,
  input  wire logic   rst_n_in,
  input  wire logic   cmd_clk_in,
  input  wire logic   cmd_data_in,
  input  wire logic   cmd_load_in,
  dmpd_cmd_if.rx      cmd
);
  localparam int W = dmpd_pkg::WORD_W;

  logic [2:0]   sync1;
  logic [2:0]   sync2;
  logic [2:0]   prev;
  logic [W-1:0] shreg;
  logic         valid;
  logic [W-1:0] word;

  wire logic clk_rise  = sync2[0] & ~prev[0];
  wire logic data_s    = sync2[1];
  wire logic load_rise = sync2[2] & ~prev[2];

  // two-stage synchronisers, then edge history
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev  <= 3'h0;
    end else begin
      sync1 <= {cmd_load_in, cmd_data_in, cmd_clk_in};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // shift msb first on link clock rise, latch on load rise
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      shreg <= '0;
      word  <= '0;
      valid <= 1'b0;
    end else begin
      valid <= load_rise;
      if (clk_rise) begin
        shreg <= {shreg[W-2:0], data_s};
      end
      if (load_rise) begin
        word <= shreg;
      end
    end
  end

  // upper digits feed the main counter, lowest digit the swallow counter
  assign cmd.word_valid  = valid;
  assign cmd.main_bcd    = word[W-1:dmpd_pkg::DIGIT_W];
  assign cmd.swallow_bcd = word[dmpd_pkg::DIGIT_W-1:0];

  a_load_gives_word: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    load_rise |=> valid && word == $past(shreg))
    else $error("command word not latched on load");
  a_shift_takes_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    clk_rise |=> shreg[0] == $past(data_s))
    else $error("serial bit not shifted in");
endmodule

// [tb/dmpd_vco_model.sv]
// behavioural oscillator with charge pump and loop filter
module dmpd_vco_model (
  input  wire logic       clock_in,
  input  wire logic       track_in,
  input  wire logic [4:0] start_per_in,
  input  wire logic       pump_up_n_in,
  input  wire logic       pump_down_n_in,
  output logic            osc_out,
  output logic [4:0]      per_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int         ctrl  = 0;
  int         per_i;
  logic [4:0] cnt   = 5'h00;

  // pump up sources charge, pump down sinks it
  always @(posedge clock_in) begin
    if (!track_in) ctrl <= 0;
    else ctrl <= ctrl + (pump_up_n_in ? 0 : 1) - (pump_down_n_in ? 0 : 1);
  end

  // more charge gives a shorter period, kept inside the safe range
  assign per_i   = int'(start_per_in) - ctrl / 32;
  assign per_out = (per_i < 6) ? 5'h06 : (per_i > 20) ? 5'h14 : per_i[4:0];

  // oscillator output, high for the first half of each period
  initial osc_out = 1'b0;
  always @(posedge clock_in) begin
    cnt     <= (cnt >= per_out - 5'h01) ? 5'h00 : cnt + 5'h01;
    osc_out <= (cnt < (per_out >> 1));
  end
endmodule

// [tb/dmpd_top_bench.sv]
// self-checking bench for the dual-modulus divider and detector
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module dmpd_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_in    = 1'b0;
  logic       rst_n_in    = 1'b0;
  logic       ref_in      = 1'b0;
  logic       cmd_clk_in  = 1'b0;
  logic       cmd_data_in = 1'b0;
  logic       cmd_load_in = 1'b0;
  logic       track       = 1'b0;
  logic [4:0] start_per   = 5'h08;
  logic       osc;
  logic       osc_q       = 1'b0;
  logic       dp          = 1'b0;
  logic       bl          = 1'b0;
  logic       divided_out;
  logic       pump_up_n_out;
  logic       pump_down_n_out;
  logic [4:0] per;
  int         mismatches  = 0;
  int         n_tests     = 0;
  int         edges       = 0;
  int         last_int    = 0;
  int         up_lo       = 0;
  int         dn_lo       = 0;

  dmpd_top u_dmpd_top (.clock_in(clock_in), .rst_n_in(rst_n_in), .osc_in(osc),
    .ref_in(ref_in), .cmd_clk_in(cmd_clk_in), .cmd_data_in(cmd_data_in),
    .cmd_load_in(cmd_load_in), .divided_out(divided_out),
    .pump_up_n_out(pump_up_n_out), .pump_down_n_out(pump_down_n_out));
  dmpd_vco_model u_dmpd_vco_model (.clock_in(clock_in), .track_in(track),
    .start_per_in(start_per), .pump_up_n_in(pump_up_n_out),
    .pump_down_n_in(pump_down_n_out), .osc_out(osc), .per_out(per));

  always #10 clock_in = ~clock_in;

  // edge count per division cycle, pulse shape and pump activity
  always @(posedge clock_in) begin
    osc_q <= osc;
    dp    <= divided_out;
    edges <= edges + ((osc && !osc_q) ? 1 : 0);
    if (divided_out === 1'b1) begin
      last_int <= edges;
      edges    <= 0;
    end
    bl    <= !pump_up_n_out && !pump_down_n_out;
    // one-sided lows only; the brief simultaneous low is not an error pulse
    if (!pump_up_n_out && pump_down_n_out) up_lo <= up_lo + 1;
    if (!pump_down_n_out && pump_up_n_out) dn_lo <= dn_lo + 1;
    if (rst_n_in) begin
      `CHK(bl & !pump_up_n_out & !pump_down_n_out, 1'b0)
      `CHK(dp & divided_out, 1'b0)
    end
  end

  task automatic final_report();
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask

  task automatic wait_pulse();
    int i;
    for (i = 0; i < 20000 && divided_out !== 1'b1; i++) tick();
    if (i == 20000) begin
      mismatches++;
      final_report();
    end else tick();
  endtask

  // msb first on the serial link, link clock still outside the frame
  task automatic send_word(input logic [15:0] w);
    for (int b = 15; b >= 0; b--) begin
      cmd_data_in = w[b];
      repeat (4) tick();
      cmd_clk_in = 1'b1;
      repeat (4) tick();
      cmd_clk_in = 1'b0;
    end
    cmd_data_in = ~w[0];
    repeat (4) tick();
    cmd_load_in = 1'b1;
    repeat (4) tick();
    cmd_load_in = 1'b0;
  endtask

  task automatic ref_run(input int p, input int n);
    repeat (n) begin
      ref_in = 1'b1;
      repeat (p / 2) tick();
      ref_in = 1'b0;
      repeat (p - p / 2) tick();
    end
  endtask

  function automatic logic [15:0] enc(input int m, input int s);
    return {4'(m / 100), 4'((m / 10) % 10), 4'(m % 10), 4'(s)};
  endfunction

  function automatic int ratio(input int m, input int s);
    return 10 * m + s;
  endfunction

  initial begin
    int i, m, s, old, nw, u0, d0;
    int w[2];
    i = $urandom(32'h0000_4067);
    repeat (16) tick();
    `CHK({divided_out, pump_up_n_out, pump_down_n_out}, 3'b011)
    rst_n_in = 1'b1;
    wait_pulse();
    wait_pulse();
    `CHK(last_int, ratio(50, 7))
    old = ratio(50, 7);
    // random words, then all-eleven and smallest ratio corners
    for (i = 0; i < 6; i++) begin
      m  = (i < 4) ? 3 + $urandom % 38 : (i == 4) ? 9 : 1;
      s  = (i < 4) ? $urandom % 10 : (i == 4) ? 9 : 0;
      s  = (s > m) ? m : s;
      nw = ratio(m, s);
      wait_pulse();
      send_word(enc(m, s));
      wait_pulse();
      `CHK(last_int, old)
      wait_pulse();
      `CHK(last_int, nw)
      old = nw;
    end
    // feedback every 80 clocks against faster and slower reference
    ref_run(60, 4);
    u0 = up_lo;
    d0 = dn_lo;
    ref_run(60, 20);
    `CHK(dn_lo - d0, 0)
    `CHK(up_lo > u0, 1'b1)
    ref_run(110, 4);
    u0 = up_lo;
    d0 = dn_lo;
    ref_run(110, 20);
    `CHK(up_lo - u0, 0)
    `CHK(dn_lo > d0, 1'b1)
    // equal frequency, reference lagging by two offsets
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 6; k++) begin
        wait_pulse();
        if (k == 1) begin
          u0 = up_lo;
          d0 = dn_lo;
        end
        repeat (5 + 10 * j) tick();
        ref_in = 1'b1;
        repeat (10) tick();
        ref_in = 1'b0;
      end
      wait_pulse();
      w[j] = dn_lo - d0;
    end
    `CHK(w[1] - w[0], 50)
    `CHK(up_lo - u0, 0)
    // closed loop pulls a slow and a fast oscillator toward the reference
    start_per = 5'h10;
    track     = 1'b1;
    ref_run(100, 5);
    `CHK(per < 5'h10, 1'b1)
    track     = 1'b0;
    start_per = 5'h06;
    tick();
    track     = 1'b1;
    ref_run(100, 5);
    `CHK(per > 5'h06, 1'b1)
    final_report();
  end
endmodule
